/* File: rtl/asp_map.svh */
// register offsets, field positions and reset values of the map
// assumes inclusion by the address space block and its package users
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// sfr byte addresses
`define ASP_SP 8'h81
`define ASP_DPL 8'h82
`define ASP_DPH 8'h83
`define ASP_POWER_CONTROL 8'h87
`define ASP_TIMER_RUN_FLAGS 8'h88
`define ASP_TIMER_MODE_SELECT 8'h89
`define ASP_TL0 8'h8A
`define ASP_TL1 8'h8B
`define ASP_TH0 8'h8C
`define ASP_TH1 8'h8D
`define ASP_P1 8'h90
`define ASP_SERIAL_CONTROL 8'h98
`define ASP_SERIAL_BUFFER 8'h99
`define ASP_P2 8'hA0
`define ASP_IEN 8'hA8
`define ASP_IPL 8'hB8
`define ASP_P3 8'hB0
`define ASP_P4 8'hBB
`define ASP_PSW 8'hD0
`define ASP_ACC 8'hE0
`define ASP_BREG 8'hF0
// timer control fields
`define ASP_T1_OVF 7
`define ASP_T1_RUN 6
`define ASP_T0_OVF 5
`define ASP_T0_RUN 4
`define ASP_EXT_FLAG 1
`define ASP_EXT_TYPE 0
// power control fields
`define ASP_BAUD_DBL 7
`define ASP_PWM_TEST 4
`define ASP_UFLAG_B 3
`define ASP_UFLAG_A 2
`define ASP_PDOWN 1
`define ASP_IDLE 0
// status word bank select
`define ASP_BANK_HI 4
`define ASP_BANK_LO 3
// reset values and fills
`define ASP_SFR_RST 8'h00
`define ASP_PORT_RST 8'hFF
`define ASP_CODE_FILL 8'hFF
// bit-addressable ram row, upper nibble
`define ASP_BIT_ROW 4'h2
// unsupported opcodes
`define ASP_OP_XRD_DPTR 8'hE0
`define ASP_OP_XWR_DPTR 8'hF0
`define ASP_OP_UNDEF 8'hA5
`endif

/* File: rtl/asp_pkg.sv */
// types shared by the address space block
// assumes nothing beyond a systemverilog compiler
package asp_pkg;
    // operand addressing modes of the internal space
    typedef enum logic [1:0]
    {
        mode_direct,
        mode_at_ri,
        mode_reg,
        mode_indirect
    } asp_mode_type;
endpackage

/* File: rtl/asp_space_map.sv */
// address spaces, sfr file, bank select and bit addressing of the core
// assumes the core issues at most one internal write per cycle
//
// Functional notes
// - 16K program space, fetch and code read
// - 256-byte data space reached through Ri
// - decode all types except the dptr moves and the undefined code
// - 256 ram bytes plus 128 sfr bytes
// - addresses 00H-7FH always lower ram
// - status word bits pick one of four banks
// - at-Ri operands take address from R0/R1
// - upper half direct is sfr, indirect ram
// - ram 20H-2FH bits map to 00H-7FH
// - sfr bit address is row plus position
// - only row-first sfrs are bit addressable
// - three ports, output port, timers, serial
// - overflow flags set by hw, cleared on vector
// - run bits start and stop the timers
// - edge flag set on edge, cleared on service
// - type bit picks falling edge or low level
// - timer control bits 3 and 2 reserved
// - baud doubler bit doubles serial rate
// - test bit routes pwm to port two from the next non-power-on reset
`timescale 1ns/1ns
`include "asp_map.svh"

module asp_space_map
#(
    parameter int CODE_AW = 14
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_flag,
    // program space
    input wire logic [15:0] fetch_addr,
    output logic [7:0] fetch_data,
    input wire logic [15:0] code_rd_addr,
    output logic [7:0] code_rd_data,
    input wire logic code_load_en,
    input wire logic [CODE_AW-1:0] code_load_addr,
    input wire logic [7:0] code_load_data,
    // data space through Ri
    input wire logic xd_rd,
    input wire logic xd_wr,
    input wire logic xd_ri_sel,
    input wire logic [7:0] xd_wdata,
    output logic [7:0] xd_rdata,
    // internal byte access
    input wire logic int_rd,
    input wire logic int_wr,
    input asp_pkg::asp_mode_type int_mode,
    input wire logic [2:0] int_reg,
    input wire logic [7:0] int_addr,
    input wire logic [7:0] int_wdata,
    output logic [7:0] int_rdata,
    // boolean access
    input wire logic bit_rd,
    input wire logic bit_wr,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    output logic bit_rdata,
    // opcode check
    input wire logic [7:0] opcode,
    output logic opcode_ok,
    // timer and interrupt events
    input wire logic [1:0] timer_ovf,
    input wire logic [1:0] timer_vec_ack,
    input wire logic ext_irq_n,
    input wire logic ext_vec_ack,
    output logic [1:0] timer_run,
    output logic [1:0] timer_ovf_flag,
    output logic ext_irq_flag,
    // power control
    output logic baud_doubler,
    output logic power_down_request,
    output logic idle_request,
    // ports
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe_n,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe_n,
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe_n,
    output logic [7:0] output_only_port,
    input wire logic [3:0] static_pwm_channels_8_to_11
);

    localparam int CODE_SIZE = 1 << CODE_AW;
    localparam logic [6:0] TIMER_RUN_FLAGS_I = 7'(`ASP_TIMER_RUN_FLAGS);
    localparam logic [6:0] POWER_CONTROL_I = 7'(`ASP_POWER_CONTROL);
    localparam logic [6:0] PSW_I = 7'(`ASP_PSW);
    localparam logic [6:0] P1_I = 7'(`ASP_P1);
    localparam logic [6:0] P2_I = 7'(`ASP_P2);
    localparam logic [6:0] P3_I = 7'(`ASP_P3);
    localparam logic [6:0] P4_I = 7'(`ASP_P4);

    // parameter range check
    generate
        if (CODE_AW < 1 || CODE_AW > 16)
        begin : g_bad_aw
            $error("code address width must be 1 to 16");
        end
    endgenerate

    // storage
    logic [7:0] scratch [0:255];
    logic [7:0] xram [0:255];
    logic [7:0] code_mem [0:CODE_SIZE-1];
    logic [7:0] sfr [0:127];
    logic ext_prev;
    logic p2_pwm_mode;

    // sfr byte decode, shared by write and both read paths
    function automatic logic sfr_mapped(input logic [7:0] a);
        case (a)
            `ASP_SP, `ASP_DPL, `ASP_DPH, `ASP_POWER_CONTROL, `ASP_TIMER_RUN_FLAGS,
            `ASP_TIMER_MODE_SELECT, `ASP_TL0, `ASP_TL1, `ASP_TH0, `ASP_TH1,
            `ASP_P1, `ASP_SERIAL_CONTROL, `ASP_SERIAL_BUFFER, `ASP_P2, `ASP_IEN,
            `ASP_P3, `ASP_IPL, `ASP_P4, `ASP_PSW, `ASP_ACC,
            `ASP_BREG: sfr_mapped = 1'b1;
            default: sfr_mapped = 1'b0;
        endcase
    endfunction

    // value software sees when reading an sfr byte
    function automatic logic [7:0] sfr_view(
        input logic [7:0] a,
        input logic [7:0] stored,
        input logic [7:0] pa,
        input logic [7:0] pb,
        input logic [7:0] pc
    );
        case (a)
            `ASP_P1: sfr_view = pa;
            `ASP_P2: sfr_view = pb;
            `ASP_P3: sfr_view = pc;
            `ASP_P4: sfr_view = 8'h00;
            default: sfr_view = sfr_mapped(a) ? stored : 8'h00;
        endcase
    endfunction

    // ram location of R0 or R1 in a bank
    function automatic logic [7:0] ri_loc(input logic [1:0] bank, input logic sel);
        ri_loc = {3'b000, bank, 2'b00, sel};
    endfunction

    // replace one bit of a byte
    function automatic logic [7:0] put_bit(
        input logic [7:0] b,
        input logic [2:0] pos,
        input logic v
    );
        logic [7:0] r;
        r = b;
        r[pos] = v;
        put_bit = r;
    endfunction

    // bank select and operand address
    logic [1:0] bank;
    logic [7:0] at_ri_addr;
    logic [7:0] eff_addr;
    logic int_is_sfr;
    assign bank = {sfr[PSW_I][`ASP_BANK_HI], sfr[PSW_I][`ASP_BANK_LO]};
    assign at_ri_addr = scratch[ri_loc(bank, int_reg[0])];
    assign eff_addr = (int_mode == asp_pkg::mode_at_ri) ? at_ri_addr :
                      (int_mode == asp_pkg::mode_reg) ? {3'b000, bank, int_reg} :
                      int_addr;
    assign int_is_sfr = (int_mode == asp_pkg::mode_direct) && eff_addr[7];

    // boolean address to byte address
    logic bit_is_sfr;
    logic [7:0] bit_byte;
    assign bit_is_sfr = bit_addr[7];
    assign bit_byte = bit_is_sfr ? {bit_addr[7:3], 3'b000} :
                      {`ASP_BIT_ROW, bit_addr[6:3]};

    // shared write path, byte write wins over bit write
    logic wr_go;
    logic wr_sfr;
    logic [7:0] wr_addr;
    logic [7:0] rmw_base;
    logic [7:0] wr_data;
    logic sfr_we;
    logic ram_we;
    assign wr_go = int_wr | bit_wr;
    assign wr_sfr = int_wr ? int_is_sfr : bit_is_sfr;
    assign wr_addr = int_wr ? eff_addr : bit_byte;
    assign rmw_base = bit_is_sfr ? sfr[bit_byte[6:0]] : scratch[bit_byte];
    assign wr_data = int_wr ? int_wdata : put_bit(rmw_base, bit_addr[2:0], bit_wdata);
    assign sfr_we = wr_go && wr_sfr && sfr_mapped(wr_addr);
    assign ram_we = wr_go && !wr_sfr;

    // software view of timer control and power control
    logic [7:0] timer_run_flags_sw;
    logic [7:0] power_control_sw;
    logic ext_set;
    logic [7:0] next_timer_run_flags;
    logic [7:0] next_power_control;
    assign timer_run_flags_sw = (sfr_we && wr_addr == `ASP_TIMER_RUN_FLAGS) ? wr_data : sfr[TIMER_RUN_FLAGS_I];
    assign power_control_sw = (sfr_we && wr_addr == `ASP_POWER_CONTROL) ? wr_data : sfr[POWER_CONTROL_I];
    // edge mode flags a falling edge, level mode a low pin
    assign ext_set = sfr[TIMER_RUN_FLAGS_I][`ASP_EXT_TYPE] ? (ext_prev & ~ext_irq_n) : ~ext_irq_n;

    // flag updates: a hardware set wins over any clear
    always_comb
    begin
        next_timer_run_flags = timer_run_flags_sw;
        next_timer_run_flags[`ASP_T1_OVF] = (timer_run_flags_sw[`ASP_T1_OVF] & ~timer_vec_ack[1]) | timer_ovf[1];
        next_timer_run_flags[`ASP_T0_OVF] = (timer_run_flags_sw[`ASP_T0_OVF] & ~timer_vec_ack[0]) | timer_ovf[0];
        next_timer_run_flags[3:2] = 2'b00;
        next_timer_run_flags[`ASP_EXT_FLAG] = (timer_run_flags_sw[`ASP_EXT_FLAG] & ~ext_vec_ack) | ext_set;
        next_power_control = power_control_sw;
        next_power_control[6:5] = 2'b00; // reserved, read zero
    end

    // sfr file
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 128; i++)
            begin
                sfr[i] <= `ASP_SFR_RST;
            end
            sfr[P1_I] <= `ASP_PORT_RST;
            sfr[P2_I] <= `ASP_PORT_RST;
            sfr[P3_I] <= `ASP_PORT_RST;
            // test bit survives all but a power-on reset
            sfr[POWER_CONTROL_I] <= {3'b000, sfr[POWER_CONTROL_I][`ASP_PWM_TEST] & ~por_flag, 4'h0};
        end
        else
        begin
            if (sfr_we)
            begin
                sfr[wr_addr[6:0]] <= wr_data;
            end
            sfr[TIMER_RUN_FLAGS_I] <= next_timer_run_flags;
            sfr[POWER_CONTROL_I] <= next_power_control;
        end
    end

    // pwm routing caught at reset, edge sampling of the interrupt pin
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            p2_pwm_mode <= sfr[POWER_CONTROL_I][`ASP_PWM_TEST] & ~por_flag;
            ext_prev <= 1'b1;
        end
        else
        begin
            ext_prev <= ext_irq_n;
        end
    end

    // scratchpad ram writes
    always_ff @(posedge clk)
    begin
        if (ram_we)
        begin
            scratch[wr_addr] <= wr_data;
        end
    end

    // data space writes, address from the selected Ri
    logic [7:0] xd_addr;
    assign xd_addr = scratch[ri_loc(bank, xd_ri_sel)];
    always_ff @(posedge clk)
    begin
        if (xd_wr)
        begin
            xram[xd_addr] <= xd_wdata;
        end
    end

    // program store loading
    always_ff @(posedge clk)
    begin
        if (code_load_en)
        begin
            code_mem[code_load_addr] <= code_load_data;
        end
    end

    // read data sources
    logic [7:0] int_rd_byte;
    logic [7:0] bit_rd_byte;
    logic fetch_in;
    logic code_rd_in;
    assign int_rd_byte = int_is_sfr ?
        sfr_view(eff_addr, sfr[eff_addr[6:0]], p1_in, p2_in, p3_in) : scratch[eff_addr];
    assign bit_rd_byte = bit_is_sfr ?
        sfr_view(bit_byte, sfr[bit_byte[6:0]], p1_in, p2_in, p3_in) : scratch[bit_byte];
    assign fetch_in = 32'(fetch_addr) < CODE_SIZE;
    assign code_rd_in = 32'(code_rd_addr) < CODE_SIZE;

    // registered read answers, one cycle after the request
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            int_rdata <= 8'h00;
            bit_rdata <= 1'b0;
            xd_rdata <= 8'h00;
            fetch_data <= 8'h00;
            code_rd_data <= 8'h00;
        end
        else
        begin
            if (int_rd)
            begin
                int_rdata <= int_rd_byte;
            end
            if (bit_rd)
            begin
                bit_rdata <= bit_rd_byte[bit_addr[2:0]];
            end
            if (xd_rd)
            begin
                xd_rdata <= xram[xd_addr];
            end
            fetch_data <= fetch_in ? code_mem[fetch_addr[CODE_AW-1:0]] : `ASP_CODE_FILL;
            code_rd_data <= code_rd_in ? code_mem[code_rd_addr[CODE_AW-1:0]] : `ASP_CODE_FILL;
        end
    end

    // the two dptr data moves and the undefined code are refused
    assign opcode_ok = !(opcode == `ASP_OP_XRD_DPTR || opcode == `ASP_OP_XWR_DPTR ||
                         opcode == `ASP_OP_UNDEF);

    // control outputs straight from the sfr flops
    assign timer_run = {sfr[TIMER_RUN_FLAGS_I][`ASP_T1_RUN], sfr[TIMER_RUN_FLAGS_I][`ASP_T0_RUN]};
    assign timer_ovf_flag = {sfr[TIMER_RUN_FLAGS_I][`ASP_T1_OVF], sfr[TIMER_RUN_FLAGS_I][`ASP_T0_OVF]};
    assign ext_irq_flag = sfr[TIMER_RUN_FLAGS_I][`ASP_EXT_FLAG];
    assign baud_doubler = sfr[POWER_CONTROL_I][`ASP_BAUD_DBL];
    assign power_down_request = sfr[POWER_CONTROL_I][`ASP_PDOWN];
    assign idle_request = sfr[POWER_CONTROL_I][`ASP_IDLE];

    // quasi-bidirectional ports: drive low for a zero latch
    assign p1_out = sfr[P1_I];
    assign p1_oe_n = sfr[P1_I];
    assign p3_out = sfr[P3_I];
    assign p3_oe_n = sfr[P3_I];
    assign p2_out = {p2_pwm_mode ? static_pwm_channels_8_to_11 : sfr[P2_I][7:4], sfr[P2_I][3:0]};
    assign p2_oe_n = {p2_pwm_mode ? 4'h0 : sfr[P2_I][7:4], sfr[P2_I][3:0]};
    assign output_only_port = sfr[P4_I];

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic timer_run_flags_byte_wr;
    assign timer_run_flags_byte_wr = int_wr && int_is_sfr && eff_addr == `ASP_TIMER_RUN_FLAGS;

    property p_ovf_set;
        timer_ovf[0] |=> timer_ovf_flag[0];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_ovf_clear;
        timer_vec_ack[1] && !timer_ovf[1] && !sfr_we |=> !timer_ovf_flag[1];
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

    property p_run_write;
        timer_run_flags_byte_wr |=> timer_run == {$past(int_wdata[6]), $past(int_wdata[4])};
    endproperty
    a_run_write: assert property (p_run_write) else $error("run bits not written");

    sequence s_fall;
        sfr[TIMER_RUN_FLAGS_I][`ASP_EXT_TYPE] && ext_prev && !ext_irq_n;
    endsequence
    property p_edge_flag;
        s_fall |=> ext_irq_flag;
    endproperty
    a_edge_flag: assert property (p_edge_flag) else $error("edge not flagged");

    property p_level_set;
        !sfr[TIMER_RUN_FLAGS_I][`ASP_EXT_TYPE] && !ext_irq_n |=> ext_irq_flag;
    endproperty
    a_level_set: assert property (p_level_set) else $error("low level not flagged");

    property p_reserved;
        sfr[TIMER_RUN_FLAGS_I][3:2] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_baud;
        int_wr && int_is_sfr && eff_addr == `ASP_POWER_CONTROL |=> baud_doubler == $past(int_wdata[7]);
    endproperty
    a_baud: assert property (p_baud) else $error("baud doubler wrong");

    sequence s_low_wr;
        int_wr && int_mode == asp_pkg::mode_direct && !int_addr[7] && !bit_wr;
    endsequence
    sequence s_low_rd;
        int_rd && !int_wr && !bit_wr && int_mode == asp_pkg::mode_direct && int_addr == $past(int_addr);
    endsequence
    property p_low_ram;
        s_low_wr ##1 s_low_rd |=> int_rdata == $past(int_wdata, 2);
    endproperty
    a_low_ram: assert property (p_low_ram) else $error("low ram readback wrong");

    property p_xdata;
        xd_wr ##1 (xd_rd && !xd_wr && !int_wr && !bit_wr && xd_ri_sel == $past(xd_ri_sel))
            |=> xd_rdata == $past(xd_wdata, 2);
    endproperty
    a_xdata: assert property (p_xdata) else $error("data space readback wrong");

    property p_bit_run;
        bit_wr && !int_wr && bit_addr == 8'h8C |=> timer_run[0] == $past(bit_wdata);
    endproperty
    a_bit_run: assert property (p_bit_run) else $error("sfr bit write lost");

    property p_opcode;
        opcode == `ASP_OP_XRD_DPTR || opcode == `ASP_OP_XWR_DPTR |-> !opcode_ok;
    endproperty
    a_opcode: assert property (p_opcode) else $error("dptr move accepted");

    property p_code_fill;
        !fetch_in |=> fetch_data == `ASP_CODE_FILL;
    endproperty
    a_code_fill: assert property (p_code_fill) else $error("out of range fetch");

    property p_pwm_route;
        p2_pwm_mode |-> p2_out[7:4] == static_pwm_channels_8_to_11 && p2_oe_n[7:4] == 4'h0;
    endproperty
    a_pwm_route: assert property (p_pwm_route) else $error("pwm routing wrong");

endmodule

/* File: verif/asp_space_map_tb.sv */
// self-checking bench for the address space and sfr map block
// assumes the map header and the package are compiled before it
`timescale 1ns/1ns
`include "asp_map.svh"

module testbench;
    localparam asp_pkg::asp_mode_type md = asp_pkg::mode_direct;
    localparam asp_pkg::asp_mode_type mi = asp_pkg::mode_indirect;
    localparam asp_pkg::asp_mode_type mr = asp_pkg::mode_reg;
    localparam asp_pkg::asp_mode_type ma = asp_pkg::mode_at_ri;
    // stimulus, all valued at time zero
    logic clk = 1'h0, rst_n = 1'h0, por_flag = 1'h1;
    logic [15:0] fetch_addr = 16'h0000, code_rd_addr = 16'h0000;
    logic code_load_en = 1'h0, xd_rd = 1'h0, xd_wr = 1'h0, xd_ri_sel = 1'h0;
    logic [13:0] code_load_addr = 14'h0000;
    logic [7:0] code_load_data = 8'h00, xd_wdata = 8'h00, int_addr = 8'h00, int_wdata = 8'h00;
    logic int_rd = 1'h0, int_wr = 1'h0, bit_rd = 1'h0, bit_wr = 1'h0, bit_wdata = 1'h0;
    asp_pkg::asp_mode_type int_mode = asp_pkg::mode_direct;
    logic [2:0] int_reg = 3'h0;
    logic [7:0] bit_addr = 8'h00, opcode = 8'h00;
    logic [1:0] timer_ovf = 2'h0, timer_vec_ack = 2'h0;
    logic ext_irq_n = 1'h1, ext_vec_ack = 1'h0;
    logic [7:0] p1_in = 8'h00, p2_in = 8'h00, p3_in = 8'h00;
    logic [3:0] static_pwm_channels_8_to_11 = 4'h0;
    // observed outputs
    logic [7:0] fetch_data, code_rd_data, xd_rdata, int_rdata, output_only_port;
    logic bit_rdata, opcode_ok, ext_irq_flag, baud_doubler, power_down_request, idle_request;
    logic [1:0] timer_run, timer_ovf_flag;
    logic [7:0] p1_out, p1_oe_n, p2_out, p2_oe_n, p3_out, p3_oe_n;
    // behavioural model state and counters
    int ram_m [256];
    int xm [256];
    int bank = 0;
    int n_errors = 0, n_tests = 0, cyc = 0;
    logic [7:0] d, e;

    asp_space_map u_asp_space_map (.*);

    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        n_tests++;
        if (g !== x)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask

    // model address of a ram operand under the current bank
    function automatic int loc(asp_pkg::asp_mode_type m, logic [2:0] r, logic [7:0] a);
        if (m == mr)
            return bank * 8 + r;
        if (m == ma)
            return ram_m[bank * 8 + r[0]];
        return a;
    endfunction

    task automatic wr(input asp_pkg::asp_mode_type m, input logic [2:0] r, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        int_wr <= 1'h1;
        int_mode <= m;
        int_reg <= r;
        int_addr <= a;
        int_wdata <= v;
        @(posedge clk);
        int_wr <= 1'h0;
        if (m == md && a == `ASP_PSW)
            bank = v[4:3];
        else if (m != md || a < 8'h80)
            ram_m[loc(m, r, a)] = v;
        @(negedge clk);
    endtask

    task automatic rd(input string n, input asp_pkg::asp_mode_type m, input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        int_rd <= 1'h1;
        int_mode <= m;
        int_addr <= a;
        @(posedge clk);
        int_rd <= 1'h0;
        @(negedge clk);
        chk(n, x, int_rdata);
    endtask

    task automatic bw(input logic [7:0] a, input logic v);
        @(posedge clk);
        bit_wr <= 1'h1;
        bit_addr <= a;
        bit_wdata <= v;
        @(posedge clk);
        bit_wr <= 1'h0;
        @(negedge clk);
    endtask

    task automatic br(input logic [7:0] a, input logic x);
        @(posedge clk);
        bit_rd <= 1'h1;
        bit_addr <= a;
        @(posedge clk);
        bit_rd <= 1'h0;
        @(negedge clk);
        chk("bit_rdata", {7'h00, x}, {7'h00, bit_rdata});
    endtask

    task automatic xacc(input logic s, input logic [7:0] v);
        @(posedge clk);
        xd_wr <= 1'h1;
        xd_ri_sel <= s;
        xd_wdata <= v;
        @(posedge clk);
        xd_wr <= 1'h0;
        xd_rd <= 1'h1;
        @(posedge clk);
        xd_rd <= 1'h0;
        @(negedge clk);
        xm[ram_m[bank * 8 + s]] = v;
        chk("xd_rdata", xm[ram_m[bank * 8 + s]], xd_rdata);
    endtask

    task automatic pulse_reset(input logic por);
        @(posedge clk);
        rst_n <= 1'h0;
        por_flag <= por;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        bank = 0;
        @(negedge clk);
    endtask

    // main sequence
    initial
    begin
        d = 8'($urandom(32'h5FF4));
        @(posedge clk);
        p1_in <= 8'($urandom);
        p3_in <= 8'($urandom);
        repeat (11) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        chk("p1_out", 8'hFF, p1_out);
        chk("p2_oe_n", 8'hFF, p2_oe_n);
        chk("p3_out", 8'hFF, p3_out);
        chk("p3_oe_n", 8'hFF, p3_oe_n);
        rd("p3 pins", md, `ASP_P3, p3_in);
        d = 8'($urandom);
        wr(md, 3'h0, `ASP_P4, d);
        chk("output_only_port", d, output_only_port);
        rd("port four", md, `ASP_P4, 8'h00);
        wr(md, 3'h0, `ASP_P1, 8'h0F);
        chk("p1_oe_n", 8'h0F, p1_oe_n);
        $display("test reset and ports done");
        // lower ram, upper ram and sfr share addresses
        wr(md, 3'h0, 8'h40, d);
        wr(mi, 3'h0, 8'h81, ~d);
        wr(md, 3'h0, `ASP_SP, d ^ 8'h3C);
        // write then read in the very next cycle
        @(posedge clk);
        int_wr <= 1'h1;
        int_mode <= md;
        int_addr <= 8'h30;
        int_wdata <= ~d;
        @(posedge clk);
        int_wr <= 1'h0;
        int_rd <= 1'h1;
        @(posedge clk);
        int_rd <= 1'h0;
        @(negedge clk);
        chk("ram 30", ~d, int_rdata);
        rd("ram 40", mi, 8'h40, ram_m[8'h40]);
        rd("ram 81", mi, 8'h81, ram_m[8'h81]);
        rd("sfr 81", md, `ASP_SP, d ^ 8'h3C);
        $display("test spaces done");
        // every bank: R0, R1, @R1 and data space access through both Ri
        for (int b = 0; b < 4; b++)
        begin
            wr(md, 3'h0, `ASP_PSW, 8'(b << 3));
            wr(mr, 3'h1, 8'h00, 8'(8'h90 + b));
            wr(mr, 3'h0, 8'h00, 8'($urandom));
            wr(ma, 3'h1, 8'h00, 8'($urandom));
            rd("bank r0", md, 8'(b * 8), ram_m[b * 8]);
            rd("at r1", mi, 8'(8'h90 + b), ram_m[8'h90 + b]);
            xacc(1'h0, 8'($urandom));
            xacc(1'h1, 8'($urandom));
        end
        $display("test banks done");
        // boolean addressing of ram and sfr rows
        wr(md, 3'h0, 8'h20, 8'h00);
        wr(md, 3'h0, 8'h2F, 8'h00);
        wr(md, 3'h0, `ASP_TH0, 8'h00);
        wr(md, 3'h0, `ASP_BREG, 8'h00);
        bw(8'h00, 1'h1);
        bw(8'h7F, 1'h1);
        bw(8'hF3, 1'h1);
        bw(8'h8C, 1'h1);
        bw(8'h8E, 1'h1);
        rd("ram 20", md, 8'h20, 8'h01);
        rd("ram 2f", md, 8'h2F, 8'h80);
        br(8'h7F, 1'h1);
        rd("b reg", md, `ASP_BREG, 8'h08);
        rd("th0", md, `ASP_TH0, 8'h00);
        chk("timer_run", 8'h03, timer_run);
        bw(8'h8C, 1'h0);
        chk("timer_run", 8'h02, timer_run);
        $display("test bits done");
        // overflow flags set, win against ack, then clear
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            timer_ovf <= 2'(1 << i);
            @(posedge clk);
            timer_ovf <= 2'(1 << i);
            timer_vec_ack <= 2'(1 << i);
            @(posedge clk);
            timer_ovf <= 2'h0;
            timer_vec_ack <= 2'h0;
            @(negedge clk);
            chk("timer_ovf_flag", 8'(1 << i), timer_ovf_flag);
            rd("timer_run_flags", md, `ASP_TIMER_RUN_FLAGS, i ? 8'hC0 : 8'h60);
            @(posedge clk);
            timer_vec_ack <= 2'(1 << i);
            @(posedge clk);
            timer_vec_ack <= 2'h0;
            @(negedge clk);
            chk("timer_ovf_flag", 8'h00, timer_ovf_flag);
        end
        // edge then level triggering of the external flag
        wr(md, 3'h0, `ASP_TIMER_RUN_FLAGS, 8'h0D);
        rd("timer_run_flags", md, `ASP_TIMER_RUN_FLAGS, 8'h01);
        @(posedge clk);
        ext_irq_n <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("ext_irq_flag", 8'h01, ext_irq_flag);
        @(posedge clk);
        ext_vec_ack <= 1'h1;
        @(posedge clk);
        ext_vec_ack <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("ext_irq_flag", 8'h00, ext_irq_flag);
        wr(md, 3'h0, `ASP_TIMER_RUN_FLAGS, 8'h00);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("ext_irq_flag", 8'h01, ext_irq_flag);
        @(posedge clk);
        ext_irq_n <= 1'h1;
        $display("test flags done");
        // power control bits, reserved bits, test bit over reset
        wr(md, 3'h0, `ASP_POWER_CONTROL, 8'hEF);
        rd("power_control", md, `ASP_POWER_CONTROL, 8'h8F);
        chk("power_control outs", 8'h07, {baud_doubler, power_down_request, idle_request});
        wr(md, 3'h0, `ASP_POWER_CONTROL, 8'h10);
        chk("power_control outs", 8'h00, {baud_doubler, power_down_request, idle_request});
        pulse_reset(1'h0);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            static_pwm_channels_8_to_11 <= k ? 4'hA : 4'h5;
            @(negedge clk);
            chk("p2 pwm", k ? 8'hA : 8'h5, p2_out[7:4]);
            chk("p2 oe", 8'h00, p2_oe_n[7:4]);
        end
        rd("power_control kept", md, `ASP_POWER_CONTROL, 8'h10);
        pulse_reset(1'h1);
        chk("p2 normal", 8'hFF, p2_out);
        $display("test power control done");
        // program store, in range and beyond
        d = 8'($urandom);
        e = 8'($urandom);
        @(posedge clk);
        code_load_en <= 1'h1;
        code_load_addr <= 14'h0123;
        code_load_data <= d;
        @(posedge clk);
        code_load_addr <= 14'h3FFF;
        code_load_data <= e;
        @(posedge clk);
        code_load_en <= 1'h0;
        fetch_addr <= 16'h0123;
        code_rd_addr <= 16'h3FFF;
        @(posedge clk);
        fetch_addr <= 16'h4000;
        @(negedge clk);
        chk("fetch_data", d, fetch_data);
        chk("code_rd_data", e, code_rd_data);
        @(negedge clk);
        chk("fetch beyond", 8'hFF, fetch_data);
        // every opcode against the supported set
        for (int op = 0; op < 256; op++)
        begin
            @(posedge clk);
            opcode <= 8'(op);
            @(negedge clk);
            chk("opcode_ok", (op == 8'hE0 || op == 8'hF0 || op == 8'hA5) ? 8'h00 : 8'h01, opcode_ok);
        end
        $display("test code and opcodes done");
        finish_test();
    end
endmodule
